// ==== inc/cpu_core_pkg.sv ====
`default_nettype none
package cpu_core_pkg;
   localparam int          DATA_W       = 8;
   localparam int          REG_COUNT    = 32;
   localparam logic [15:0] DS_REG_TOP   = 16'h001F;
   localparam logic [4:0]  PTR_BASE_IDX = 5'h1A;
   localparam logic [15:0] SP_RESET     = 16'h08FF;
   localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
   localparam logic [15:0] SP_STEP_ADDR = 16'h0002;
   localparam logic [7:0]  REG_RESET    = 8'h00;
   localparam logic [7:0]  FLAGS_RESET  = 8'h00;
   localparam int          FLAG_I       = 7;
   localparam int          FLAG_T       = 6;
   localparam int          FLAG_H       = 5;
   localparam int          FLAG_S       = 4;
   localparam int          FLAG_V       = 3;
   localparam int          FLAG_N       = 2;
   localparam int          FLAG_Z       = 1;
   localparam int          FLAG_C       = 0;

   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SUBI, OP_AND, OP_OR, OP_EOR,
      OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_MOV, OP_LDI, OP_ADIW, OP_WADD,
      OP_MOVW, OP_BST, OP_BLD, OP_SEI, OP_CLI, OP_PUSH, OP_POP, OP_LD, OP_ST,
      OP_CALL, OP_RET, OP_IRQ_RETURN_INSN
   } op_t;

   typedef enum logic [1:0] {PM_DISP, PM_POSTINC, PM_PREDEC} ptr_mode_t;
   typedef enum logic [1:0] {IO_FLAGS, IO_SP_LOW, IO_SP_HIGH} io_sel_t;

   typedef struct packed {
      op_t       op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
      logic [2:0] bit_idx;
      logic [1:0] ptr_sel;
      ptr_mode_t ptr_mode;
      logic [5:0] disp;
   } insn_t;

   typedef struct packed {
      logic [15:0] res;
      logic [7:0]  flags;
   } alu_out_t;
endpackage : cpu_core_pkg
`default_nettype wire

// ==== rtl/alu_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module alu_unit (
   input  wire cpu_core_pkg::op_t   op,       // Operation in execute
   input  wire logic [7:0]          opa,      // Destination register operand
   input  wire logic [7:0]          opb,      // Source register operand
   input  wire logic [15:0]         opw,      // Destination register pair
   input  wire logic [7:0]          imm,      // Immediate operand
   input  wire logic [7:0]          flags_in, // Current flags
   output cpu_core_pkg::alu_out_t   y         // Result and new flags
);
   // Returns {carry, half carry, overflow, result}
   function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin, input logic sub);
      logic [8:0] s;
      logic [4:0] ns;
      logic       v;
      if (sub) begin
         s  = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         ns = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
         v  = (a[7] != b[7]) && (s[7] != a[7]);
      end else begin
         s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         ns = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         v  = (a[7] == b[7]) && (s[7] != a[7]);
      end
      return {s[8], ns[4], v, s[7:0]};
   endfunction : addsub

   logic [10:0] as;
   logic        arith;
   logic        cf;
   logic [7:0]  r;
   logic [15:0] w;
   logic [7:0]  f;

   always_comb begin
      cf    = flags_in[cpu_core_pkg::FLAG_C];
      arith = 1'b1;
      r     = opa;
      w     = 16'h0000;
      f     = flags_in;
      case (op)
         cpu_core_pkg::OP_ADD:  as = addsub(opa, opb, 1'b0, 1'b0);
         cpu_core_pkg::OP_ADC:  as = addsub(opa, opb, cf, 1'b0);
         cpu_core_pkg::OP_SUB:  as = addsub(opa, opb, 1'b0, 1'b1);
         cpu_core_pkg::OP_SBC:  as = addsub(opa, opb, cf, 1'b1);
         cpu_core_pkg::OP_SUBI: as = addsub(opa, imm, 1'b0, 1'b1);
         cpu_core_pkg::OP_NEG:  as = addsub(8'h00, opa, 1'b0, 1'b1);
         cpu_core_pkg::OP_INC:  as = addsub(opa, 8'h01, 1'b0, 1'b0);
         cpu_core_pkg::OP_DEC:  as = addsub(opa, 8'h01, 1'b0, 1'b1);
         default: begin
            as    = 11'h000;
            arith = 1'b0;
         end
      endcase
      if (arith) begin
         r                         = as[7:0];
         f[cpu_core_pkg::FLAG_V]   = as[8];
         f[cpu_core_pkg::FLAG_N]   = r[7];
         f[cpu_core_pkg::FLAG_Z]   = (r == 8'h00);
         if (op != cpu_core_pkg::OP_INC && op != cpu_core_pkg::OP_DEC) begin
            f[cpu_core_pkg::FLAG_C] = as[10];
            f[cpu_core_pkg::FLAG_H] = as[9];
         end
         // Chained subtract with carry keeps zero only if all bytes were zero
         if (op == cpu_core_pkg::OP_SBC) begin
            f[cpu_core_pkg::FLAG_Z] = (r == 8'h00) && flags_in[cpu_core_pkg::FLAG_Z];
         end
      end
      case (op)
         cpu_core_pkg::OP_AND, cpu_core_pkg::OP_OR, cpu_core_pkg::OP_EOR,
         cpu_core_pkg::OP_COM, cpu_core_pkg::OP_LSR: begin
            case (op)
               cpu_core_pkg::OP_AND: r = opa & opb;
               cpu_core_pkg::OP_OR:  r = opa | opb;
               cpu_core_pkg::OP_EOR: r = opa ^ opb;
               cpu_core_pkg::OP_COM: r = ~opa;
               default:              r = {1'b0, opa[7:1]};
            endcase
            f[cpu_core_pkg::FLAG_N] = r[7];
            f[cpu_core_pkg::FLAG_Z] = (r == 8'h00);
            f[cpu_core_pkg::FLAG_V] = 1'b0;
            if (op == cpu_core_pkg::OP_COM) begin
               f[cpu_core_pkg::FLAG_C] = 1'b1;
            end
            if (op == cpu_core_pkg::OP_LSR) begin
               f[cpu_core_pkg::FLAG_C] = opa[0];
               f[cpu_core_pkg::FLAG_V] = opa[0];
            end
         end
         cpu_core_pkg::OP_MOV:  r = opb;
         cpu_core_pkg::OP_LDI:  r = imm;
         cpu_core_pkg::OP_MOVW: w = opw;
         cpu_core_pkg::OP_ADIW: begin
            w = opw + {8'h00, imm};
            f[cpu_core_pkg::FLAG_C] = ~w[15] & opw[15];
            f[cpu_core_pkg::FLAG_V] = ~opw[15] & w[15];
            f[cpu_core_pkg::FLAG_N] = w[15];
            f[cpu_core_pkg::FLAG_Z] = (w == 16'h0000);
         end
         cpu_core_pkg::OP_WADD: begin
            w = {8'h00, opa} + {8'h00, opb};
            f[cpu_core_pkg::FLAG_C] = 1'b0;
            f[cpu_core_pkg::FLAG_V] = 1'b0;
            f[cpu_core_pkg::FLAG_N] = 1'b0;
            f[cpu_core_pkg::FLAG_Z] = (w == 16'h0000);
         end
         default: ;
      endcase
      f[cpu_core_pkg::FLAG_S] = f[cpu_core_pkg::FLAG_N] ^ f[cpu_core_pkg::FLAG_V];
      y.flags = f;
      y.res   = (w != 16'h0000 || op == cpu_core_pkg::OP_MOVW || op == cpu_core_pkg::OP_ADIW
                 || op == cpu_core_pkg::OP_WADD) ? w : {8'h00, r};
   end
endmodule : alu_unit
`default_nettype wire

// ==== rtl/cpu_exec_core.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_exec_core #(
   parameter logic [15:0] SP_TOP = cpu_core_pkg::SP_RESET // Top of data memory
) (
   input  wire logic                 core_clk,   // Core clock
   input  wire logic                 arst_n,     // Asynchronous reset
   input  wire logic                 insn_valid, // Fetch bus holds an instruction
   input  wire cpu_core_pkg::insn_t  insn,       // Fetched instruction
   input  wire logic [15:0]          ret_addr,   // Return address to push
   input  wire logic                 irq_req,    // Pending enabled interrupt
   output logic                      irq_taken,  // Interrupt entry this cycle
   output logic [15:0]               mem_addr,   // Data memory address
   output logic                      mem_we,     // Data memory write
   output logic                      mem_re,     // Data memory read
   output logic                      mem_wide,   // Two-byte transfer
   output logic [15:0]               mem_wdata,  // Write data
   input  wire logic [15:0]          mem_rdata,  // Read data, same cycle
   input  wire logic [15:0]          ds_addr,    // Data-space address
   input  wire logic                 ds_we,      // Data-space write
   input  wire logic [7:0]           ds_wdata,   // Data-space write data
   output logic [7:0]                ds_rdata,   // Data-space read data
   input  wire cpu_core_pkg::io_sel_t io_sel,    // I/O register select
   input  wire logic                 io_we,      // I/O register write
   input  wire logic [7:0]           io_wdata,   // I/O write data
   output logic [7:0]                io_rdata,   // I/O read data
   output logic [7:0]                flags,      // Status flags register
   output logic [15:0]               sp,         // Stack pointer
   output logic [15:0]               ret_pc,     // Popped return address
   output logic                      pc_load     // Pulse: load ret_pc
);
   logic [7:0]            regs      [cpu_core_pkg::REG_COUNT];
   logic [7:0]            next_regs [cpu_core_pkg::REG_COUNT];
   cpu_core_pkg::insn_t   cur;
   cpu_core_pkg::insn_t   next_cur;
   logic                  cur_valid;
   logic                  next_cur_valid;
   logic [7:0]            next_flags;
   logic [15:0]           next_sp;
   logic [15:0]           next_ret_pc;
   logic                  next_pc_load;
   cpu_core_pkg::alu_out_t alu_y;
   logic [4:0]            pl;
   logic [4:0]            rd_lo;
   logic [4:0]            rd_hi;
   logic [15:0]           ptr;
   logic [15:0]           ptr_new;
   logic [15:0]           ea;
   logic                  bst_bit;
   logic                  ds_hit;

   function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
      return cpu_core_pkg::PTR_BASE_IDX + {2'b00, sel, 1'b0};
   endfunction : ptr_lo

   function automatic logic alu8_op(input cpu_core_pkg::op_t op);
      case (op)
         cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC, cpu_core_pkg::OP_SUB,
         cpu_core_pkg::OP_SBC, cpu_core_pkg::OP_SUBI, cpu_core_pkg::OP_AND,
         cpu_core_pkg::OP_OR, cpu_core_pkg::OP_EOR, cpu_core_pkg::OP_COM,
         cpu_core_pkg::OP_NEG, cpu_core_pkg::OP_INC, cpu_core_pkg::OP_DEC,
         cpu_core_pkg::OP_LSR: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : alu8_op

   assign rd_lo   = {cur.rd[4:1], 1'b0};
   assign rd_hi   = {cur.rd[4:1], 1'b1};
   assign pl      = ptr_lo(cur.ptr_sel);
   assign ptr     = {regs[pl | 5'h01], regs[pl]};
   assign bst_bit = regs[cur.rd][cur.bit_idx];
   assign ds_hit  = (ds_addr <= cpu_core_pkg::DS_REG_TOP);

   alu_unit u_alu (
      .op       (cur.op),
      .opa      (regs[cur.rd]),
      .opb      (regs[cur.rr]),
      .opw      ({regs[rd_hi], regs[rd_lo]}),
      .imm      (cur.imm),
      .flags_in (flags),
      .y        (alu_y)
   );

   assign irq_taken = irq_req & flags[cpu_core_pkg::FLAG_I] & ~cur_valid;

   assign ds_rdata = ds_hit ? regs[ds_addr[4:0]] : 8'h00;

   always_comb begin
      case (io_sel)
         cpu_core_pkg::IO_FLAGS:   io_rdata = flags;
         cpu_core_pkg::IO_SP_LOW:  io_rdata = sp[7:0];
         cpu_core_pkg::IO_SP_HIGH: io_rdata = sp[15:8];
         default:                  io_rdata = 8'h00;
      endcase
   end

   always_comb begin
      next_cur       = insn;
      next_cur_valid = insn_valid;
   end

   always_comb begin
      case (cur.ptr_mode)
         cpu_core_pkg::PM_POSTINC: begin
            ea      = ptr;
            ptr_new = ptr + cpu_core_pkg::SP_STEP_BYTE;
         end
         cpu_core_pkg::PM_PREDEC: begin
            ptr_new = ptr - cpu_core_pkg::SP_STEP_BYTE;
            ea      = ptr_new;
         end
         default: begin
            ea      = ptr + {10'h000, cur.disp};
            ptr_new = ptr;
         end
      endcase
   end

   always_comb begin
      next_regs    = regs;
      next_flags   = flags;
      next_sp      = sp;
      next_ret_pc  = ret_pc;
      next_pc_load = 1'b0;
      mem_addr     = 16'h0000;
      mem_we       = 1'b0;
      mem_re       = 1'b0;
      mem_wide     = 1'b0;
      mem_wdata    = 16'h0000;
      // flags untouched on entry except enable
      if (irq_taken) begin
         next_flags[cpu_core_pkg::FLAG_I] = 1'b0;
         mem_addr  = sp - cpu_core_pkg::SP_STEP_BYTE;
         mem_we    = 1'b1;
         mem_wide  = 1'b1;
         mem_wdata = ret_addr;
         next_sp   = sp - cpu_core_pkg::SP_STEP_ADDR;
      end else if (cur_valid) begin
         if (alu8_op(cur.op)) begin
            next_regs[cur.rd] = alu_y.res[7:0];
            next_flags        = alu_y.flags;
         end
         case (cur.op)
            cpu_core_pkg::OP_MOV, cpu_core_pkg::OP_LDI: next_regs[cur.rd] = alu_y.res[7:0];
            cpu_core_pkg::OP_ADIW, cpu_core_pkg::OP_WADD, cpu_core_pkg::OP_MOVW: begin
               next_regs[rd_lo] = alu_y.res[7:0];
               next_regs[rd_hi] = alu_y.res[15:8];
               if (cur.op != cpu_core_pkg::OP_MOVW) begin
                  next_flags = alu_y.flags;
               end
            end
            cpu_core_pkg::OP_BST: next_flags[cpu_core_pkg::FLAG_T] = bst_bit;
            cpu_core_pkg::OP_BLD: next_regs[cur.rd][cur.bit_idx] = flags[cpu_core_pkg::FLAG_T];
            cpu_core_pkg::OP_SEI: next_flags[cpu_core_pkg::FLAG_I] = 1'b1;
            cpu_core_pkg::OP_CLI: next_flags[cpu_core_pkg::FLAG_I] = 1'b0;
            cpu_core_pkg::OP_PUSH: begin
               mem_addr  = sp;
               mem_we    = 1'b1;
               mem_wdata = {8'h00, regs[cur.rd]};
               next_sp   = sp - cpu_core_pkg::SP_STEP_BYTE;
            end
            cpu_core_pkg::OP_POP: begin
               mem_addr          = sp + cpu_core_pkg::SP_STEP_BYTE;
               mem_re            = 1'b1;
               next_regs[cur.rd] = mem_rdata[7:0];
               next_sp           = sp + cpu_core_pkg::SP_STEP_BYTE;
            end
            cpu_core_pkg::OP_LD, cpu_core_pkg::OP_ST: begin
               mem_addr = ea;
               if (cur.op == cpu_core_pkg::OP_LD) begin
                  mem_re            = 1'b1;
                  next_regs[cur.rd] = mem_rdata[7:0];
               end else begin
                  mem_we    = 1'b1;
                  mem_wdata = {8'h00, regs[cur.rd]};
               end
               next_regs[pl]         = ptr_new[7:0];
               next_regs[pl | 5'h01] = ptr_new[15:8];
            end
            cpu_core_pkg::OP_CALL: begin
               mem_addr  = sp - cpu_core_pkg::SP_STEP_BYTE;
               mem_we    = 1'b1;
               mem_wide  = 1'b1;
               mem_wdata = ret_addr;
               next_sp   = sp - cpu_core_pkg::SP_STEP_ADDR;
            end
            cpu_core_pkg::OP_RET, cpu_core_pkg::OP_IRQ_RETURN_INSN: begin
               mem_addr     = sp + cpu_core_pkg::SP_STEP_BYTE;
               mem_re       = 1'b1;
               mem_wide     = 1'b1;
               next_ret_pc  = mem_rdata;
               next_pc_load = 1'b1;
               next_sp      = sp + cpu_core_pkg::SP_STEP_ADDR;
               if (cur.op == cpu_core_pkg::OP_IRQ_RETURN_INSN) begin
                  next_flags[cpu_core_pkg::FLAG_I] = 1'b1;
               end
            end
            default: ;
         endcase
      end else begin
         if (ds_we && ds_hit) begin
            next_regs[ds_addr[4:0]] = ds_wdata;
         end
         if (io_we) begin
            case (io_sel)
               cpu_core_pkg::IO_SP_LOW:  next_sp[7:0]  = io_wdata;
               cpu_core_pkg::IO_SP_HIGH: next_sp[15:8] = io_wdata;
               cpu_core_pkg::IO_FLAGS: begin
                  next_flags = io_wdata;
                  next_flags[cpu_core_pkg::FLAG_S] = io_wdata[cpu_core_pkg::FLAG_N]
                                                     ^ io_wdata[cpu_core_pkg::FLAG_V];
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < cpu_core_pkg::REG_COUNT; i++) begin
            regs[i] <= cpu_core_pkg::REG_RESET;
         end
         cur       <= '0;
         cur_valid <= 1'b0;
         flags     <= cpu_core_pkg::FLAGS_RESET;
         sp        <= SP_TOP;
         ret_pc    <= 16'h0000;
         pc_load   <= 1'b0;
      end else begin
         regs      <= next_regs;
         cur       <= next_cur;
         cur_valid <= next_cur_valid;
         flags     <= next_flags;
         sp        <= next_sp;
         ret_pc    <= next_ret_pc;
         pc_load   <= next_pc_load;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_sign_flag: assert property (
      flags[cpu_core_pkg::FLAG_S] == (flags[cpu_core_pkg::FLAG_N] ^ flags[cpu_core_pkg::FLAG_V]))
      else $error("sign flag differs from N xor V");
   a_irq_gate: assert property (
      irq_taken |-> flags[cpu_core_pkg::FLAG_I])
      else $error("interrupt taken while disabled");
   a_irq_clear: assert property (
      irq_taken |=> !flags[cpu_core_pkg::FLAG_I] && !irq_taken)
      else $error("enable not cleared on entry");
   a_flags_kept: assert property (
      irq_taken |=> flags[6:0] == $past(flags[6:0]))
      else $error("flags changed on interrupt entry");
   a_irq_stack: assert property (
      irq_taken || (cur_valid && cur.op == cpu_core_pkg::OP_CALL)
      |=> sp == $past(sp) - cpu_core_pkg::SP_STEP_ADDR)
      else $error("entry did not drop stack by two");
   a_irq_return_insn_pop: assert property (
      !irq_taken && cur_valid && cur.op == cpu_core_pkg::OP_IRQ_RETURN_INSN
      |=> flags[cpu_core_pkg::FLAG_I] && pc_load ##1 (!pc_load || $past(cur_valid)))
      else $error("irq return did not set enable");
   a_push_step: assert property (
      !irq_taken && cur_valid && cur.op == cpu_core_pkg::OP_PUSH
      |=> sp == $past(sp) - cpu_core_pkg::SP_STEP_BYTE)
      else $error("push did not drop stack by one");
   a_alu_result: assert property (
      !irq_taken && cur_valid && alu8_op(cur.op)
      |=> regs[$past(cur.rd)] == $past(alu_y.res[7:0]))
      else $error("ALU result not written next cycle");
   a_zero_flag: assert property (
      !irq_taken && cur_valid && cur.op == cpu_core_pkg::OP_ADD
      |=> flags[cpu_core_pkg::FLAG_Z] == (regs[$past(cur.rd)] == 8'h00))
      else $error("zero flag wrong after add");
   a_bit_store: assert property (
      !irq_taken && cur_valid && cur.op == cpu_core_pkg::OP_BST
      |=> flags[cpu_core_pkg::FLAG_T] == $past(bst_bit))
      else $error("bit store lost the bit");
   a_ds_write: assert property (
      !cur_valid && !irq_taken && ds_we && ds_hit
      |=> ds_addr != $past(ds_addr) || ds_rdata == $past(ds_wdata))
      else $error("data-space write to register lost");
endmodule : cpu_exec_core
`default_nettype wire

// ==== sim/cpu_flags_regfile_stack_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("Error %0t: got %h expected %h", $time, a, e); end end
module cpu_flags_regfile_stack_tb_top;
   localparam logic [15:0] SP_TOP = 16'h08FF;
   logic                  core_clk = 1'b0;
   logic                  arst_n = 1'b0;
   logic                  insn_valid = 1'b0;
   cpu_core_pkg::insn_t   insn = '0;
   logic [15:0]           ret_addr = 16'h0000;
   logic                  irq_req = 1'b0;
   logic [15:0]           mem_rdata = 16'h0000;
   logic [15:0]           ds_addr = 16'h0000;
   logic                  ds_we = 1'b0;
   logic [7:0]            ds_wdata = 8'h00;
   cpu_core_pkg::io_sel_t io_sel = cpu_core_pkg::IO_FLAGS;
   logic                  io_we = 1'b0;
   logic [7:0]            io_wdata = 8'h00;
   logic                  irq_taken, mem_we, mem_re, mem_wide, pc_load;
   logic [15:0]           mem_addr, mem_wdata, sp, ret_pc;
   logic [7:0]            ds_rdata, io_rdata, flags, a, b, e8;
   logic [2:0]            bit_sel = 3'h0;
   logic [31:0]           lfsr = 32'h0894;
   int                    n_mismatch = 0;
   int                    checks_done = 0;
   cpu_exec_core #(.SP_TOP(SP_TOP)) u_cpu_exec_core (.core_clk(core_clk), .arst_n(arst_n),
      .insn_valid(insn_valid), .insn(insn), .ret_addr(ret_addr), .irq_req(irq_req),
      .irq_taken(irq_taken), .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
      .mem_wide(mem_wide), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ds_addr(ds_addr),
      .ds_we(ds_we), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .io_sel(io_sel),
      .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata), .flags(flags), .sp(sp),
      .ret_pc(ret_pc), .pc_load(pc_load));
   always #5 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic [7:0] add_flags(input logic [7:0] x, y, f);
      logic [8:0] s;
      logic [4:0] h;
      logic       v;
      s = {1'b0, x} + {1'b0, y};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
      v = (x[7] == y[7]) && (s[7] != x[7]);
      return {f[7:6], h[4], s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
   endfunction : add_flags
   // Memory strobes are sampled inside the execute cycle, results after it
   task automatic exec(input cpu_core_pkg::op_t op, input logic [4:0] rd, rr);
      cpu_core_pkg::insn_t i;
      i = '0;
      i.op = op;
      i.rd = rd;
      i.rr = rr;
      i.bit_idx = bit_sel;
      @(posedge core_clk) insn_valid <= 1'b1;
      insn <= i;
      @(posedge core_clk) insn_valid <= 1'b0;
      #1;
   endtask : exec
   task automatic ds_wr(input logic [15:0] ad, input logic [7:0] d);
      @(posedge core_clk) ds_we <= 1'b1;
      ds_addr <= ad;
      ds_wdata <= d;
      @(posedge core_clk) ds_we <= 1'b0;
   endtask : ds_wr
   task automatic ds_chk(input logic [15:0] ad, input logic [7:0] e);
      @(posedge core_clk) ds_addr <= ad;
      #1 `CHK(ds_rdata, e)
   endtask : ds_chk
   task automatic io_wr(input cpu_core_pkg::io_sel_t s, input logic [7:0] d);
      @(posedge core_clk) io_we <= 1'b1;
      io_sel <= s;
      io_wdata <= d;
      @(posedge core_clk) io_we <= 1'b0;
      #1;
   endtask : io_wr
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      #1 `CHK(flags, 8'h00)
      `CHK(sp, SP_TOP)
      io_sel <= cpu_core_pkg::IO_SP_HIGH;
      #1 `CHK(io_rdata, SP_TOP[15:8])
      $display("reset test done");
      for (int k = 0; k < 8; k++) begin
         lfsr = lfsr_next(lfsr);
         a = (k == 0) ? 8'h7F : lfsr[7:0];
         b = (k == 0) ? 8'h01 : lfsr[15:8];
         ds_wr(16'h0001, a);
         ds_wr(16'h0002, b);
         exec(cpu_core_pkg::OP_ADD, 5'h01, 5'h02);
         @(posedge core_clk) #1 `CHK(flags, add_flags(a, b, 8'h00))
         `CHK(flags[4], flags[2] ^ flags[3])
         ds_chk(16'h0001, a + b);
      end
      ds_chk(16'h0020, 8'h00);
      $display("alu test done");
      io_wr(cpu_core_pkg::IO_FLAGS, 8'h48);
      `CHK(flags, 8'h58)
      `CHK(io_rdata, 8'h58)
      io_wr(cpu_core_pkg::IO_SP_LOW, 8'h40);
      `CHK(sp, {SP_TOP[15:8], 8'h40})
      `CHK(io_rdata, 8'h40)
      exec(cpu_core_pkg::OP_PUSH, 5'h01, 5'h00);
      `CHK({mem_we, mem_addr}, {1'b1, SP_TOP[15:8], 8'h40})
      `CHK(mem_wdata, {8'h00, a + b})
      @(posedge core_clk) #1 `CHK(sp, {SP_TOP[15:8], 8'h3F})
      mem_rdata <= {8'h00, ~a};
      exec(cpu_core_pkg::OP_POP, 5'h03, 5'h00);
      `CHK({mem_re, mem_addr}, {1'b1, SP_TOP[15:8], 8'h40})
      @(posedge core_clk) #1 `CHK(sp, {SP_TOP[15:8], 8'h40})
      ds_chk(16'h0003, ~a);
      lfsr = lfsr_next(lfsr);
      ret_addr <= lfsr[15:0];
      exec(cpu_core_pkg::OP_CALL, 5'h00, 5'h00);
      `CHK({mem_wide, mem_wdata}, {1'b1, lfsr[15:0]})
      `CHK({mem_we, mem_addr}, {1'b1, SP_TOP[15:8], 8'h3F})
      @(posedge core_clk) #1 `CHK(sp, {SP_TOP[15:8], 8'h3E})
      mem_rdata <= lfsr[31:16];
      exec(cpu_core_pkg::OP_IRQ_RETURN_INSN, 5'h00, 5'h00);
      for (int w = 0; w < 8 && pc_load !== 1'b1; w++) @(posedge core_clk) #1;
      `CHK({pc_load, ret_pc}, {1'b1, lfsr[31:16]})
      `CHK(flags, 8'hD8)
      `CHK(sp, {SP_TOP[15:8], 8'h40})
      $display("stack test done");
      irq_req <= 1'b1;
      #1 `CHK({irq_taken, mem_wide, mem_addr}, {2'b11, SP_TOP[15:8], 8'h3F})
      @(posedge core_clk) irq_req <= 1'b0;
      #1 `CHK(flags, 8'h58)
      `CHK(sp, {SP_TOP[15:8], 8'h3E})
      exec(cpu_core_pkg::OP_SEI, 5'h00, 5'h00);
      @(posedge core_clk) #1 `CHK(flags, 8'hD8)
      exec(cpu_core_pkg::OP_NOP, 5'h00, 5'h00);
      irq_req <= 1'b1;
      #1 `CHK(irq_taken, 1'b0)
      irq_req <= 1'b0;
      exec(cpu_core_pkg::OP_CLI, 5'h00, 5'h00);
      @(posedge core_clk) #1 `CHK(flags, 8'h58)
      irq_req <= 1'b1;
      #1 `CHK(irq_taken, 1'b0)
      irq_req <= 1'b0;
      e8 = a + b;
      bit_sel = lfsr[18:16];
      exec(cpu_core_pkg::OP_BST, 5'h01, 5'h00);
      @(posedge core_clk) #1 `CHK(flags[6], e8[bit_sel])
      a = ~a;
      a[bit_sel] = e8[bit_sel];
      exec(cpu_core_pkg::OP_BLD, 5'h03, 5'h00);
      ds_chk(16'h0003, a);
      $display("interrupt test done");
      close_out();
   end
endmodule : cpu_flags_regfile_stack_tb_top
`default_nettype wire
